// ===== hw/dcfd_field_hold.sv
`timescale 1ns/100ps
`default_nettype none

module dcfd_field_hold #(
    parameter int W = 1
) (
    input  wire logic         i_ref_clk,  // System clock
    input  wire logic         i_reset,    // Sync reset, loads storage value
    input  wire logic [W-1:0] i_nv_val,   // Value from nonvolatile storage
    input  wire logic         i_wr_en,    // Self-programming update now
    input  wire logic [W-1:0] i_wr_val,   // Self-programming value
    output logic      [W-1:0] o_val       // Held value
);

    logic [W-1:0] next_val;

    // Storage copy during reset, otherwise take writes that apply now
    always_comb begin
        if (i_reset) begin
            next_val = i_nv_val;
        end else if (i_wr_en) begin
            next_val = i_wr_val;
        end else begin
            next_val = o_val;
        end
    end

    // Holding register
    always_ff @(posedge i_ref_clk) begin
        o_val <= next_val;
    end

endmodule : dcfd_field_hold

`default_nettype wire

// ===== hw/dcfd_osc_start.sv
`timescale 1ns/100ps
`default_nettype none

module dcfd_osc_start (
    input  wire logic              i_ref_clk,   // System clock
    input  wire logic              i_reset,     // Sync reset, active high
    input  wire logic              i_two_speed, // Held two-speed start-up enable
    input  wire dcfd_pkg::dcfd_osc_t i_sel_osc, // Held selected source
    input  wire logic              i_sel_ready, // Selected source is stable
    output dcfd_pkg::dcfd_osc_t    o_osc_src,   // Source now clocking the core
    output logic                   o_busy       // Still running on the RC
);

    typedef enum logic [1:0] {ST_BOOT, ST_FRC, ST_SEL} dcfd_st_t;

    dcfd_st_t            state;
    dcfd_st_t            next_state;
    dcfd_pkg::dcfd_osc_t next_src;
    logic                next_busy;

    // Start on the fast RC when two-speed start-up is on, else go direct
    always_comb begin
        next_state = state;
        case (state)
            ST_BOOT: begin
                next_state = i_two_speed ? ST_FRC : ST_SEL;
            end
            ST_FRC: begin
                if (i_sel_ready) begin
                    next_state = ST_SEL;
                end
            end
            ST_SEL: begin
                next_state = ST_SEL;
            end
            default: begin
                next_state = ST_BOOT;
            end
        endcase
        if (i_reset) begin
            next_state = ST_BOOT;
        end
        next_src  = (next_state == ST_SEL) ? i_sel_osc : dcfd_pkg::OSC_FRC;
        next_busy = (next_state != ST_SEL);
    end

    // State and output registers
    always_ff @(posedge i_ref_clk) begin
        state     <= next_state;
        o_osc_src <= next_src;
        o_busy    <= next_busy;
    end

    property p_two_speed_frc;
        @(posedge i_ref_clk) disable iff (i_reset)
        (state == ST_FRC && !i_sel_ready) |=> (o_osc_src == dcfd_pkg::OSC_FRC) && o_busy;
    endproperty
    a_two_speed_frc: assert property (p_two_speed_frc) else $error("RC not held");

endmodule : dcfd_osc_start

`default_nettype wire

// ===== hw/dcfd_pkg.sv
package dcfd_pkg;

    // Decoded security level of a memory segment
    typedef enum logic [1:0] {SEC_NONE, SEC_STD, SEC_HIGH} dcfd_sec_t;

    // Initial oscillator source, in the order of its 3-bit code
    typedef enum logic [2:0] {
        OSC_FRC, OSC_FRC_PLL, OSC_PRI, OSC_PRI_PLL,
        OSC_SEC, OSC_LOW_POWER_INTERNAL_RC, OSC_FRC_DIV16, OSC_FRC_POST
    } dcfd_osc_t;

    // Primary oscillator mode, in the order of its 2-bit code
    typedef enum logic [1:0] {POSC_EC, POSC_XT, POSC_HS, POSC_OFF} dcfd_posc_t;

    // Raw configuration fields as held in nonvolatile storage (17 bits, MSB first)
    typedef struct packed {
        logic       boot_write_protect;           // Bit 16
        logic [2:0] boot_segment_size_security;   // Bits 15:13
        logic [1:0] general_code_protect;         // Bits 12:11
        logic       general_write_protect;        // Bit 10
        logic [1:0] clock_switch_monitor_mode;    // Bits 9:8
        logic       pin_select_single_reconfig;   // Bit 7
        logic       osc_out_pin_function;         // Bit 6
        logic [1:0] primary_osc_mode;             // Bits 5:4
        logic       two_speed_startup_en;         // Bit 3
        logic [2:0] initial_osc_select;           // Bits 2:0
    } dcfd_cfg_t;

    localparam int CFG_W  = 17;
    localparam int OSC_W  = 3;
    localparam int REST_W = 14;

    // Decoded effects seen by memory, clock and pin-select logic
    typedef struct packed {
        logic       boot_wr_en;
        logic       boot_present;
        dcfd_sec_t  boot_sec;
        logic [23:0] boot_end;
        logic [10:0] boot_words;
        dcfd_sec_t  gen_sec;
        logic       gen_wr_en;
        logic       two_speed;
        dcfd_osc_t  init_osc;
        logic       clk_switch_en;
        logic       fail_safe_en;
        logic       pps_single;
        dcfd_posc_t posc;
        logic       osc_out_clk;
        logic       osc_out_gpio;
    } dcfd_dec_t;

    // Boot segment geometry
    localparam logic [23:0] BOOT_START     = 24'h000200;
    localparam logic [23:0] BOOT_END_256   = 24'h0003fe;
    localparam logic [23:0] BOOT_END_768   = 24'h0007fe;
    localparam logic [23:0] BOOT_END_1792  = 24'h000ffe;
    localparam logic [10:0] BOOT_WORDS_256 = 11'h100;
    localparam logic [10:0] BOOT_WORDS_768 = 11'h300;
    localparam logic [10:0] BOOT_WORDS_1792 = 11'h700;

    // Register byte offsets
    localparam logic [31:0] REG_CFG_ACTIVE  = 32'h00000000;
    localparam logic [31:0] REG_CFG_PROGRAM = 32'h00000004;
    localparam logic [31:0] REG_PPS_CTRL    = 32'h00000008;
    localparam logic [31:0] REG_PM_CHECK    = 32'h0000000c;
    localparam logic [31:0] REG_OSC_STATUS  = 32'h00000010;

    // Bus constants and reset values
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;
    localparam logic [31:0] HRDATA_RST    = 32'h00000000;
    localparam logic        HREADY_RST    = 1'h1;
    localparam logic [23:0] PM_ADDR_RST   = 24'h000000;

endpackage : dcfd_pkg

// ===== hw/dcfd_top.sv
// Function
// - Boot write-protect bit gates boot writes immediately
// - Size code x11 means no boot segment
// - Codes 110/010: 256 words, end 0x0003FE
// - Codes 101/001: 768 words, end 0x0007FE
// - Codes 100/000: 1792 words, end 0x000FFE
// - General protect: 11 none, 10 standard, 0x high
// - General write-protect bit gates user writes immediately
// - Two-speed start: RC first, then selected source
// - Decode eight initial oscillator source codes
// - Oscillator select deferred to reset if switching enabled
// - Switch mode: 1x off, 01 switch, 00 both
// - Single-reconfig bit allows one pin remap only
// - Non-crystal modes: clock out or GPIO on pin
// - Primary mode: off, HS, XT, external clock
`timescale 1ns/100ps
`default_nettype none

module dcfd_top (
    input  wire logic                i_ref_clk,      // System clock, 125 MHz
    input  wire logic                i_reset,        // Sync reset, active high
    input  wire dcfd_pkg::dcfd_cfg_t i_nv_cfg,       // Fields in nonvolatile storage
    input  wire logic                i_sel_osc_ready,// Selected oscillator ready
    input  wire logic                i_hsel,         // AHB slave select
    input  wire logic [31:0]         i_haddr,        // AHB address
    input  wire logic [1:0]          i_htrans,       // AHB transfer type
    input  wire logic                i_hwrite,       // AHB write
    input  wire logic [2:0]          i_hsize,        // AHB size
    input  wire logic [31:0]         i_hwdata,       // AHB write data
    input  wire logic                i_hready,       // AHB bus ready
    output logic                     o_hreadyout,    // AHB slave ready
    output logic                     o_hresp,        // AHB response, always OKAY
    output logic [31:0]              o_hrdata,       // AHB read data
    output dcfd_pkg::dcfd_dec_t      o_dec,          // Decoded configuration
    output dcfd_pkg::dcfd_osc_t      o_osc_running,  // Source clocking the core
    output logic                     o_two_speed_busy, // Running on RC at start-up
    output logic                     o_pps_reconfig, // Pin remap granted, pulse
    output logic                     o_nv_wr,        // Storage write, pulse
    output dcfd_pkg::dcfd_cfg_t      o_nv_data       // Storage write data
);

    // Decode held fields into their effects
    function automatic dcfd_pkg::dcfd_dec_t decode(input dcfd_pkg::dcfd_cfg_t c);
        dcfd_pkg::dcfd_dec_t d;
        logic                xtal;
        d = '0;
        d.boot_wr_en   = c.boot_write_protect;
        d.boot_present = (c.boot_segment_size_security[1:0] != 2'h3);
        case (c.boot_segment_size_security[1:0])
            2'h2: begin
                d.boot_end   = dcfd_pkg::BOOT_END_256;
                d.boot_words = dcfd_pkg::BOOT_WORDS_256;
            end
            2'h1: begin
                d.boot_end   = dcfd_pkg::BOOT_END_768;
                d.boot_words = dcfd_pkg::BOOT_WORDS_768;
            end
            2'h0: begin
                d.boot_end   = dcfd_pkg::BOOT_END_1792;
                d.boot_words = dcfd_pkg::BOOT_WORDS_1792;
            end
            default: begin
                d.boot_end   = 24'h000000;
                d.boot_words = 11'h000;
            end
        endcase
        if (!d.boot_present) begin
            d.boot_sec = dcfd_pkg::SEC_NONE;
        end else if (c.boot_segment_size_security[2]) begin
            d.boot_sec = dcfd_pkg::SEC_STD;
        end else begin
            d.boot_sec = dcfd_pkg::SEC_HIGH;
        end
        case (c.general_code_protect)
            2'h3:    d.gen_sec = dcfd_pkg::SEC_NONE;
            2'h2:    d.gen_sec = dcfd_pkg::SEC_STD;
            default: d.gen_sec = dcfd_pkg::SEC_HIGH;
        endcase
        d.gen_wr_en     = c.general_write_protect;
        d.two_speed     = c.two_speed_startup_en;
        d.init_osc      = dcfd_pkg::dcfd_osc_t'(c.initial_osc_select);
        d.clk_switch_en = !c.clock_switch_monitor_mode[1];
        d.fail_safe_en  = (c.clock_switch_monitor_mode == 2'h0);
        d.pps_single    = c.pin_select_single_reconfig;
        d.posc          = dcfd_pkg::dcfd_posc_t'(c.primary_osc_mode);
        xtal            = (d.posc == dcfd_pkg::POSC_XT) || (d.posc == dcfd_pkg::POSC_HS);
        d.osc_out_clk   = !xtal && c.osc_out_pin_function;
        d.osc_out_gpio  = !xtal && !c.osc_out_pin_function;
        return d;
    endfunction : decode

    dcfd_pkg::dcfd_cfg_t cfg_q;
    logic [13:0]         held_rest;
    logic [2:0]          held_osc;
    dcfd_pkg::dcfd_cfg_t sp_data;
    logic                sp_wr;
    logic                osc_wr;
    logic                switch_en;
    logic                addr_acc;
    logic                wr_pend;
    logic                rd_pend;
    logic [31:0]         addr_q;
    logic                next_wr_pend;
    logic                next_rd_pend;
    logic [31:0]         next_addr_q;
    logic                next_hreadyout;
    logic [31:0]         next_hrdata;
    logic                pps_used;
    logic                pps_req;
    logic                pps_grant;
    logic                next_pps_used;
    logic [23:0]         pm_addr;
    logic [23:0]         next_pm_addr;
    logic                pm_in_boot;
    logic                pm_allow;
    dcfd_pkg::dcfd_dec_t next_dec;
    dcfd_pkg::dcfd_cfg_t next_nv_data;

    // Self-programming writes arrive through the program register
    assign sp_data   = dcfd_pkg::dcfd_cfg_t'(i_hwdata[dcfd_pkg::CFG_W-1:0]);
    assign sp_wr     = wr_pend && (addr_q == dcfd_pkg::REG_CFG_PROGRAM);
    assign switch_en = !cfg_q.clock_switch_monitor_mode[1];
    assign osc_wr    = sp_wr && !switch_en;
    assign cfg_q     = dcfd_pkg::dcfd_cfg_t'({held_rest, held_osc});

    // Held fields that change at once on a self-programming write
    dcfd_field_hold #(
        .W (dcfd_pkg::REST_W)
    ) u_hold_rest (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_nv_val  (i_nv_cfg[dcfd_pkg::CFG_W-1:dcfd_pkg::OSC_W]),
        .i_wr_en   (sp_wr),
        .i_wr_val  (sp_data[dcfd_pkg::CFG_W-1:dcfd_pkg::OSC_W]),
        .o_val     (held_rest)
    );

    // Oscillator select waits for reset while switching is enabled
    dcfd_field_hold #(
        .W (dcfd_pkg::OSC_W)
    ) u_hold_osc (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_nv_val  (i_nv_cfg.initial_osc_select),
        .i_wr_en   (osc_wr),
        .i_wr_val  (sp_data.initial_osc_select),
        .o_val     (held_osc)
    );

    // Start-up oscillator sequencing
    dcfd_osc_start u_osc_start (
        .i_ref_clk   (i_ref_clk),
        .i_reset     (i_reset),
        .i_two_speed (cfg_q.two_speed_startup_en),
        .i_sel_osc   (dcfd_pkg::dcfd_osc_t'(cfg_q.initial_osc_select)),
        .i_sel_ready (i_sel_osc_ready),
        .o_osc_src   (o_osc_running),
        .o_busy      (o_two_speed_busy)
    );

    // Program address check against the current segment layout
    always_comb begin
        pm_in_boot = o_dec.boot_present && (pm_addr >= dcfd_pkg::BOOT_START)
                     && (pm_addr <= o_dec.boot_end);
        pm_allow   = pm_in_boot ? o_dec.boot_wr_en : o_dec.gen_wr_en;
    end

    // AHB slave: writes take no wait state, reads take one
    always_comb begin
        addr_acc       = i_hsel && i_hready && (i_htrans == dcfd_pkg::HTRANS_NONSEQ)
                         && (i_hsize == dcfd_pkg::HSIZE_WORD);
        next_wr_pend   = addr_acc && i_hwrite;
        next_rd_pend   = addr_acc && !i_hwrite;
        next_addr_q    = addr_acc ? i_haddr : addr_q;
        next_hreadyout = !next_rd_pend;
        next_hrdata    = o_hrdata;
        if (rd_pend) begin
            case (addr_q)
                dcfd_pkg::REG_CFG_ACTIVE:  next_hrdata = {15'h0000, cfg_q};
                dcfd_pkg::REG_CFG_PROGRAM: next_hrdata = {15'h0000, o_nv_data};
                dcfd_pkg::REG_PPS_CTRL:    next_hrdata = {30'h00000000,
                                                          o_dec.pps_single && pps_used,
                                                          pps_used};
                dcfd_pkg::REG_PM_CHECK:    next_hrdata = {6'h00, pm_allow, pm_in_boot,
                                                          pm_addr};
                dcfd_pkg::REG_OSC_STATUS:  next_hrdata = {28'h0000000, o_two_speed_busy,
                                                          o_osc_running};
                default:                   next_hrdata = dcfd_pkg::HRDATA_RST;
            endcase
        end
        if (i_reset) begin
            next_wr_pend   = 1'h0;
            next_rd_pend   = 1'h0;
            next_hreadyout = dcfd_pkg::HREADY_RST;
            next_hrdata    = dcfd_pkg::HRDATA_RST;
        end
    end

    // AHB slave registers
    always_ff @(posedge i_ref_clk) begin
        wr_pend     <= next_wr_pend;
        rd_pend     <= next_rd_pend;
        addr_q      <= next_addr_q;
        o_hreadyout <= next_hreadyout;
        o_hrdata    <= next_hrdata;
        o_hresp     <= 1'h0;
    end

    // Pin-select remap requests and the address under check
    always_comb begin
        pps_req       = wr_pend && (addr_q == dcfd_pkg::REG_PPS_CTRL) && i_hwdata[0];
        pps_grant     = pps_req && !(o_dec.pps_single && pps_used);
        next_pps_used = pps_used || pps_grant;
        next_pm_addr  = (wr_pend && (addr_q == dcfd_pkg::REG_PM_CHECK)) ?
                        i_hwdata[23:0] : pm_addr;
        if (i_reset) begin
            next_pps_used = 1'h0;
            next_pm_addr  = dcfd_pkg::PM_ADDR_RST;
            pps_grant     = 1'h0;
        end
    end

    // Remap state registers
    always_ff @(posedge i_ref_clk) begin
        pps_used       <= next_pps_used;
        o_pps_reconfig <= pps_grant;
        pm_addr        <= next_pm_addr;
    end

    // Decoded outputs follow the held fields; storage image follows writes
    always_comb begin
        next_dec     = decode(i_reset ? i_nv_cfg : cfg_q);
        next_nv_data = i_reset ? i_nv_cfg : (sp_wr ? sp_data : o_nv_data);
    end

    // Output registers
    always_ff @(posedge i_ref_clk) begin
        o_dec     <= next_dec;
        o_nv_wr   <= sp_wr && !i_reset;
        o_nv_data <= next_nv_data;
    end

    property p_boot_wr;
        @(posedge i_ref_clk) disable iff (i_reset)
        sp_wr |-> ##2 (o_dec.boot_wr_en == $past(sp_data.boot_write_protect, 2));
    endproperty
    a_boot_wr: assert property (p_boot_wr) else $error("Boot write gate late");

    property p_no_boot;
        @(posedge i_ref_clk) disable iff (i_reset)
        (cfg_q.boot_segment_size_security[1:0] == 2'h3) |=> !o_dec.boot_present
            && (o_dec.boot_sec == dcfd_pkg::SEC_NONE);
    endproperty
    a_no_boot: assert property (p_no_boot) else $error("Boot segment present");

    property p_boot_256;
        @(posedge i_ref_clk) disable iff (i_reset)
        (cfg_q.boot_segment_size_security[1:0] == 2'h2) |=>
            (o_dec.boot_end == 24'h0003fe) && (o_dec.boot_words == 11'h100);
    endproperty
    a_boot_256: assert property (p_boot_256) else $error("Small boot size wrong");

    property p_boot_768;
        @(posedge i_ref_clk) disable iff (i_reset)
        (cfg_q.boot_segment_size_security[1:0] == 2'h1) |=>
            (o_dec.boot_end == 24'h0007fe) && (o_dec.boot_words == 11'h300);
    endproperty
    a_boot_768: assert property (p_boot_768) else $error("Medium boot size wrong");

    property p_boot_1792;
        @(posedge i_ref_clk) disable iff (i_reset)
        (cfg_q.boot_segment_size_security[1:0] == 2'h0) |=>
            (o_dec.boot_end == 24'h000ffe) && (o_dec.boot_words == 11'h700);
    endproperty
    a_boot_1792: assert property (p_boot_1792) else $error("Large boot size wrong");

    property p_gen_high;
        @(posedge i_ref_clk) disable iff (i_reset)
        !cfg_q.general_code_protect[1] |=> (o_dec.gen_sec == dcfd_pkg::SEC_HIGH);
    endproperty
    a_gen_high: assert property (p_gen_high) else $error("General not high security");

    property p_gen_wr;
        @(posedge i_ref_clk) disable iff (i_reset)
        sp_wr |-> ##2 (o_dec.gen_wr_en == $past(sp_data.general_write_protect, 2));
    endproperty
    a_gen_wr: assert property (p_gen_wr) else $error("User write gate late");

    property p_init_osc;
        @(posedge i_ref_clk) disable iff (i_reset)
        ##1 (o_dec.init_osc == dcfd_pkg::dcfd_osc_t'($past(cfg_q.initial_osc_select)));
    endproperty
    a_init_osc: assert property (p_init_osc) else $error("Oscillator decode wrong");

    property p_osc_defer;
        @(posedge i_ref_clk) disable iff (i_reset)
        (sp_wr && switch_en) |=> $stable(cfg_q.initial_osc_select);
    endproperty
    a_osc_defer: assert property (p_osc_defer) else $error("Oscillator change not deferred");

    property p_no_switch;
        @(posedge i_ref_clk) disable iff (i_reset)
        cfg_q.clock_switch_monitor_mode[1] |=> !o_dec.clk_switch_en && !o_dec.fail_safe_en;
    endproperty
    a_no_switch: assert property (p_no_switch) else $error("Switching not disabled");

    property p_pps_once;
        @(posedge i_ref_clk) disable iff (i_reset)
        (pps_req && o_dec.pps_single && pps_used) |=> !o_pps_reconfig;
    endproperty
    a_pps_once: assert property (p_pps_once) else $error("Second remap granted");

    property p_osc_pin_xtal;
        @(posedge i_ref_clk) disable iff (i_reset)
        (cfg_q.primary_osc_mode inside {2'h1, 2'h2}) |=> !o_dec.osc_out_clk
            && !o_dec.osc_out_gpio;
    endproperty
    a_osc_pin_xtal: assert property (p_osc_pin_xtal) else $error("Crystal pin reused");

    property p_posc;
        @(posedge i_ref_clk) disable iff (i_reset)
        (cfg_q.primary_osc_mode == 2'h3) |=> (o_dec.posc == dcfd_pkg::POSC_OFF);
    endproperty
    a_posc: assert property (p_posc) else $error("Primary not disabled");

    property p_reset_load;
        @(posedge i_ref_clk) disable iff (i_reset)
        $fell(i_reset) |-> (cfg_q == $past(i_nv_cfg));
    endproperty
    a_reset_load: assert property (p_reset_load) else $error("Storage not loaded");

endmodule : dcfd_top

`default_nettype wire

// ===== tb/dcfd_top_tb.sv
`timescale 1ns/100ps
`default_nettype none

module dcfd_top_tb;
    logic                i_ref_clk = 1'b0;
    logic                i_reset   = 1'b1;
    logic                ready     = 1'b0;
    logic                hsel      = 1'b0;
    logic                hwrite    = 1'b0;
    logic [1:0]          htrans    = 2'h0;
    logic [2:0]          hsize     = 3'h0;
    logic [31:0]         haddr     = 32'h0;
    logic [31:0]         hwdata    = 32'h0;
    logic [31:0]         hrdata;
    logic [31:0]         r;
    logic                hrdy;
    logic                hresp;
    logic                busy;
    dcfd_pkg::dcfd_cfg_t nv = '0;
    dcfd_pkg::dcfd_cfg_t cur;
    dcfd_pkg::dcfd_cfg_t w;
    dcfd_pkg::dcfd_cfg_t mdl;
    dcfd_pkg::dcfd_dec_t dec_o;
    dcfd_pkg::dcfd_osc_t osc_run;
    dcfd_pkg::dcfd_cfg_t nv_data;
    logic                pps;
    logic                nvw;
    logic                inb;
    logic [3:0]          e4;
    logic [31:0]         pa;
    dcfd_pkg::dcfd_dec_t d_exp;
    integer              seed = 32'h842e;
    integer              num_errors = 0;
    integer              n_tests = 0;
    integer              pulses = 0;

    dcfd_top dcfd_top_inst (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_nv_cfg(nv),
        .i_sel_osc_ready(ready), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy),
        .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata), .o_dec(dec_o),
        .o_osc_running(osc_run), .o_two_speed_busy(busy), .o_pps_reconfig(pps),
        .o_nv_wr(nvw), .o_nv_data(nv_data));

    // Clock and remap pulse counter
    always #4 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) if (pps === 1'b1) pulses <= pulses + 1;

    // Expected decode of one set of held fields
    function automatic dcfd_pkg::dcfd_dec_t dec(input dcfd_pkg::dcfd_cfg_t c);
        logic [2:0] b;
        b = c.boot_segment_size_security;
        dec = '0;
        dec.boot_wr_en = c.boot_write_protect;
        dec.boot_present = (b[1:0] != 2'h3);
        dec.boot_sec = (b[1:0] == 2'h3) ? dcfd_pkg::SEC_NONE :
            b[2] ? dcfd_pkg::SEC_STD : dcfd_pkg::SEC_HIGH;
        case (b[1:0])
            2'h2: {dec.boot_end, dec.boot_words} = {24'h0003fe, 11'h100};
            2'h1: {dec.boot_end, dec.boot_words} = {24'h0007fe, 11'h300};
            2'h0: {dec.boot_end, dec.boot_words} = {24'h000ffe, 11'h700};
            default: dec.boot_end = 24'h0;
        endcase
        dec.gen_sec = (c.general_code_protect == 2'h3) ? dcfd_pkg::SEC_NONE :
            (c.general_code_protect == 2'h2) ? dcfd_pkg::SEC_STD : dcfd_pkg::SEC_HIGH;
        dec.gen_wr_en = c.general_write_protect;
        dec.two_speed = c.two_speed_startup_en;
        dec.init_osc = dcfd_pkg::dcfd_osc_t'(c.initial_osc_select);
        dec.clk_switch_en = ~c.clock_switch_monitor_mode[1];
        dec.fail_safe_en = (c.clock_switch_monitor_mode == 2'h0);
        dec.pps_single = c.pin_select_single_reconfig;
        dec.posc = dcfd_pkg::dcfd_posc_t'(c.primary_osc_mode);
        b[0] = (c.primary_osc_mode == 2'h1) || (c.primary_osc_mode == 2'h2);
        dec.osc_out_clk = c.osc_out_pin_function & ~b[0];
        dec.osc_out_gpio = ~c.osc_out_pin_function & ~b[0];
    endfunction : dec

    // Boot geometry is left unchecked where no boot segment exists
    function automatic dcfd_pkg::dcfd_dec_t msk(input dcfd_pkg::dcfd_cfg_t c);
        msk = '1;
        if (c.boot_segment_size_security[1:0] == 2'h3) begin
            {msk.boot_end, msk.boot_words} = '0;
        end
    endfunction : msk

    task automatic cmp(input logic [63:0] g, input logic [63:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : cmp

    // One AHB single transfer, waiting on hready in both phases
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        {hsel, hwrite, haddr} <= {1'b1, wr, a};
        {htrans, hsize} <= {dcfd_pkg::HTRANS_NONSEQ, dcfd_pkg::HSIZE_WORD};
        do @(posedge i_ref_clk); while (hrdy !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge i_ref_clk); while (hrdy !== 1'b1);
        r = hrdata;
        cmp(hresp, 1'b0);
    endtask : ahb

    task automatic rst(input int n);
        {nv, i_reset, ready} <= {cur, 1'b1, 1'b0};
        repeat (n) @(posedge i_ref_clk);
        i_reset <= 1'b0;
    endtask : rst

    task automatic report_and_stop;
        if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    // Watchdog
    initial begin
        repeat (5000) @(posedge i_ref_clk);
        num_errors++;
        report_and_stop;
    end

    // Reset load, start-up, remap, program and deferral sequence
    initial begin
        cur = dcfd_pkg::dcfd_cfg_t'($random(seed));
        for (int i = 0; i < 16; i++) begin
            rst(i == 0 ? 20 : 2);
            mdl = cur;
            cmp(dec_o & msk(mdl), dec(mdl) & msk(mdl));
            repeat (3) @(posedge i_ref_clk);
            e4 = mdl.two_speed_startup_en ? 4'h8 : {1'b0, mdl.initial_osc_select};
            cmp({busy, osc_run}, e4);
            ready <= 1'b1;
            repeat (3) @(posedge i_ref_clk);
            cmp({busy, osc_run}, {1'b0, mdl.initial_osc_select});
            ahb(1'b0, dcfd_pkg::REG_OSC_STATUS, 32'h0);
            cmp(r, {28'h0, 1'b0, mdl.initial_osc_select});
            ahb(1'b0, dcfd_pkg::REG_CFG_ACTIVE, 32'h0);
            cmp(r, {15'h0, mdl});
            pulses = 0;
            ahb(1'b1, dcfd_pkg::REG_PPS_CTRL, 32'h1);
            ahb(1'b1, dcfd_pkg::REG_PPS_CTRL, 32'h1);
            repeat (2) @(posedge i_ref_clk);
            cmp(pulses, mdl.pin_select_single_reconfig ? 1 : 2);
            ahb(1'b0, dcfd_pkg::REG_PPS_CTRL, 32'h0);
            cmp(r, {30'h0, mdl.pin_select_single_reconfig, 1'b1});
            w = dcfd_pkg::dcfd_cfg_t'($random(seed));
            {w.boot_segment_size_security, w.clock_switch_monitor_mode} = {i[2:0], i[3:2]};
            ahb(1'b1, dcfd_pkg::REG_CFG_PROGRAM, {15'h0, w});
            if (!mdl.clock_switch_monitor_mode[1]) begin
                w.initial_osc_select = mdl.initial_osc_select;
            end
            @(posedge i_ref_clk);
            cmp(nvw, 1'b1);
            @(posedge i_ref_clk);
            cmp(nvw, 1'b0);
            cmp(dec_o & msk(w), dec(w) & msk(w));
            w = nv_data;
            cmp(w, dcfd_pkg::dcfd_cfg_t'(hwdata));
            cur = dcfd_pkg::dcfd_cfg_t'(hwdata);
            // Program address check against the segment layout just written
            d_exp = dec(cur);
            pa = $random(seed) & 32'h00000fff;
            inb = d_exp.boot_present && (pa >= dcfd_pkg::BOOT_START)
                  && (pa <= d_exp.boot_end);
            ahb(1'b1, dcfd_pkg::REG_PM_CHECK, pa);
            ahb(1'b0, dcfd_pkg::REG_PM_CHECK, 32'h0);
            cmp(r, {6'h0, inb ? d_exp.boot_wr_en : d_exp.gen_wr_en, inb, pa[23:0]});
        end
        ahb(1'b0, 32'h00000040, 32'h0);
        cmp(r, 32'h0);
        report_and_stop;
    end
endmodule : dcfd_top_tb

`default_nettype wire
